// >>> mim_irq_mask_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module mim_irq_mask_ctrl
   import mim_pkg::*;
#(
   parameter int PULSE_CYCLES = MIM_PULSE_CYCLES
) (
   input  wire logic           ref_clk_in,
   input  wire logic           resetn_in,
   input  wire logic [6:0]     reg_addr_in,
   input  wire logic           reg_wr_in,
   input  wire logic           reg_rd_in,
   input  wire logic [7:0]     reg_wdata_in,
   output logic [7:0]          reg_rdata_out,
   input  wire logic [7:0]     first_flags_in,
   input  wire logic           cfg_mgmt_irq_en_in,
   input  wire logic           cfg_host_irq_en_in,
   input  wire logic           cfg_int_clear_in,
   input  wire logic           cfg_host_nmi_sel_in,
   input  wire logic           cfg_reset_req_in,
   output logic                reset_done_out,
   output logic                reset_pulse_n_out,
   input  wire logic           positive_channel_four_limit_in,
   input  wire logic           inverting_channel_a_limit_in,
   input  wire logic           inverting_channel_b_limit_in,
   input  wire logic           third_tachometer_limit_in,
   input  wire logic           case_open_pin_in,
   output logic                case_open_pin_out,
   output logic                case_open_pin_oe_n_out,
   input  wire logic           post_write_in,
   input  wire logic [4:0]     post_ptr_in,
   input  wire logic           chained_irq_in_pin_in,
   input  wire logic [3:0]     voltage_ident_inputs_in,
   input  wire logic           first_tachometer_in,
   input  wire logic           second_tachometer_in,
   output logic                first_tachometer_div_out,
   output logic                second_tachometer_div_out,
   output logic [6:0]          serial_slave_address_out,
   output logic                mgmt_irq_n_out,
   output logic                host_irq_out
);
   typedef struct packed {
      logic [6:0] flags2;
      logic [7:0] mgmt_lo;
      logic [7:0] mgmt_hi;
      logic [7:0] host_lo;
      logic [7:0] host_hi;
      logic [3:0] fan_div;
      logic [6:0] slave;
      logic [7:0] rdata;
      logic       mgmt_irq;
      logic       host_pin;
      logic       rst_armed;
      logic [2:0] first_tachometer_cnt;
      logic [2:0] second_tachometer_cnt;
      logic       first_tachometer_out;
      logic       second_tachometer_out;
   } mim_state_type;

   localparam mim_state_type RST_STATE = '{
      flags2:    MIM_RST_FLAGS2,
      mgmt_lo:   MIM_RST_MGMT_LO,
      mgmt_hi:   MIM_RST_MGMT_HI,
      host_lo:   MIM_RST_HOST_LO,
      host_hi:   MIM_RST_HOST_HI,
      fan_div:   MIM_RST_FAN_DIV,
      slave:     MIM_RST_SLAVE,
      rdata:     8'h00,
      mgmt_irq:  1'b0,
      host_pin:  1'b1,
      rst_armed: 1'b0,
      first_tachometer_cnt:  3'h0,
      second_tachometer_cnt:  3'h0,
      first_tachometer_out:  1'b0,
      second_tachometer_out:  1'b0
   };

   logic [1:0]            rst_sync_q;
   logic                  rst_n;
   mim_state_type         q;
   mim_state_type         d;
   logic [MIM_EV_NUM-1:0] ev_g;
   logic                  rd_flags;
   logic                  pend_mgmt;
   logic                  pend_host;
   logic                  host_act;

   mim_pulse_if case_pl ();
   mim_pulse_if rst_pl ();

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // tach prescaler tick: every 2^sel-th pulse
   function automatic logic tach_tick(input logic [2:0] cnt, input logic [1:0] sel);
      logic [2:0] mask;
      mask = 3'h0;
      unique case (sel)
         2'b00: mask = 3'h0;
         2'b01: mask = 3'h1;
         2'b10: mask = 3'h3;
         2'b11: mask = 3'h7;
      endcase
      return (cnt & mask) == mask;
   endfunction

   always_comb begin
      ev_g = '0;
      ev_g[MIM_EV_CH4]   = positive_channel_four_limit_in;
      ev_g[MIM_EV_INV_A] = inverting_channel_a_limit_in;
      ev_g[MIM_EV_INV_B] = inverting_channel_b_limit_in;
      ev_g[MIM_EV_TACH3] = third_tachometer_limit_in;
      // own clear pulse pulls the pin low, so no false event
      ev_g[MIM_EV_CASE]  = case_open_pin_in && !case_pl.busy;
      ev_g[MIM_EV_POST_FULL] = post_write_in && (post_ptr_in == MIM_POST_LAST);
      ev_g[MIM_EV_CHAIN] = !chained_irq_in_pin_in;
      // monitoring stops while interrupt-clear is set
      if (cfg_int_clear_in) begin
         ev_g = '0;
      end
   end

   assign rd_flags = reg_rd_in && (reg_addr_in == MIM_ADDR_FLAGS2);

   // first flags gated by management mask low
   // second flags gated by management mask high
   assign pend_mgmt = |(first_flags_in & ~q.mgmt_lo) | |(q.flags2 & ~q.mgmt_hi[6:0]);
   // first flags gated by host mask low
   // second flags gated by host mask high
   assign pend_host = |(first_flags_in & ~q.host_lo) | |(q.flags2 & ~q.host_hi[6:0]);
   assign host_act  = cfg_host_irq_en_in && !cfg_int_clear_in && pend_host;

   // clear pulse runs while the self-clearing bit is set
   assign case_pl.start = q.host_hi[MIM_BIT_CASE_CLEAR] && !case_pl.busy;
   // reset pulse only while its enable bit is set
   assign rst_pl.start  = cfg_reset_req_in && q.mgmt_hi[MIM_BIT_RESET_EN]
                          && !q.rst_armed && !rst_pl.busy;

   always_comb begin
      d = q;
      // flags are cleared by reading them; a new event in that cycle wins
      d.flags2 = (rd_flags ? 7'h00 : q.flags2) | ev_g;

      if (reg_wr_in) begin
         unique case (reg_addr_in)
            MIM_ADDR_MGMT_LO: d.mgmt_lo = reg_wdata_in;
            MIM_ADDR_MGMT_HI: d.mgmt_hi = reg_wdata_in;
            MIM_ADDR_HOST_LO: d.host_lo = reg_wdata_in;
            MIM_ADDR_HOST_HI: begin
               d.host_hi[6:0] = reg_wdata_in[6:0];
               // a request during a running pulse is dropped
               if (reg_wdata_in[MIM_BIT_CASE_CLEAR] && !case_pl.busy) begin
                  d.host_hi[MIM_BIT_CASE_CLEAR] = 1'b1;
               end
            end
            // divisor fields writable, identification bits are not
            MIM_ADDR_DIV_VID: d.fan_div = reg_wdata_in[7:4];
            MIM_ADDR_SLAVE:   d.slave = reg_wdata_in[6:0];
            default: ;
         endcase
      end
      // bit clears itself at the end of the pulse
      if (case_pl.done) begin
         d.host_hi[MIM_BIT_CASE_CLEAR] = 1'b0;
      end

      if (reg_rd_in) begin
         unique case (reg_addr_in)
            MIM_ADDR_FLAGS2:  d.rdata = {1'b0, q.flags2};
            MIM_ADDR_MGMT_LO: d.rdata = q.mgmt_lo;
            MIM_ADDR_MGMT_HI: d.rdata = q.mgmt_hi;
            MIM_ADDR_HOST_LO: d.rdata = q.host_lo;
            MIM_ADDR_HOST_HI: d.rdata = q.host_hi;
            MIM_ADDR_DIV_VID: d.rdata = {q.fan_div, voltage_ident_inputs_in};
            MIM_ADDR_SLAVE:   d.rdata = {1'b0, q.slave};
            default:          d.rdata = 8'h00;
         endcase
      end

      // level request: re-arm only once software drops it
      d.rst_armed = cfg_reset_req_in && (q.rst_armed || rst_pl.start);

      d.mgmt_irq = cfg_mgmt_irq_en_in && !cfg_int_clear_in && pend_mgmt;
      d.host_pin = cfg_host_nmi_sel_in ? host_act : !host_act;

      if (first_tachometer_in) begin
         d.first_tachometer_cnt = q.first_tachometer_cnt + 3'h1;
      end
      d.first_tachometer_out = first_tachometer_in
                   && tach_tick(q.first_tachometer_cnt, q.fan_div[MIM_FIRST_TACHOMETER_LSB-4 +: 2]);
      if (second_tachometer_in) begin
         d.second_tachometer_cnt = q.second_tachometer_cnt + 3'h1;
      end
      d.second_tachometer_out = second_tachometer_in
                   && tach_tick(q.second_tachometer_cnt, q.fan_div[MIM_SECOND_TACHOMETER_LSB-4 +: 2]);
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST_STATE;
      end else begin
         q <= d;
      end
   end

   mim_pulse_timer #(
      .CYCLES (PULSE_CYCLES)
   ) u_case_pulse (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n),
      .pl         (case_pl)
   );

   mim_pulse_timer #(
      .CYCLES (PULSE_CYCLES)
   ) u_reset_pulse (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n),
      .pl         (rst_pl)
   );

   assign reg_rdata_out             = q.rdata;
   assign mgmt_irq_n_out            = !q.mgmt_irq;
   assign host_irq_out              = q.host_pin;
   assign first_tachometer_div_out  = q.first_tachometer_out;
   assign second_tachometer_div_out = q.second_tachometer_out;
   assign serial_slave_address_out  = q.slave;
   assign case_open_pin_out         = 1'b0;
   assign case_open_pin_oe_n_out    = !case_pl.busy;
   assign reset_pulse_n_out         = !rst_pl.busy;
   assign reset_done_out            = rst_pl.done;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n);

   a_flags_capture: assert property ((|ev_g) |=> ((q.flags2 & $past(ev_g)) == $past(ev_g)))
      else $error("event did not set its flag");
   a_flags_frozen: assert property (cfg_int_clear_in && !rd_flags |=> q.flags2 == $past(q.flags2))
      else $error("flags changed during interrupt clear");
   a_outputs_quiet: assert property (cfg_int_clear_in |=>
         mgmt_irq_n_out && (host_irq_out == !$past(cfg_host_nmi_sel_in)))
      else $error("output active during interrupt clear");
   a_mgmt_asserts: assert property (cfg_mgmt_irq_en_in && !cfg_int_clear_in && pend_mgmt
         |=> !mgmt_irq_n_out)
      else $error("unmasked flag did not assert management output");
   a_mgmt_enable: assert property (!cfg_mgmt_irq_en_in |=> mgmt_irq_n_out)
      else $error("management output active while disabled");
   a_mask_blocks: assert property (!pend_mgmt |=> mgmt_irq_n_out)
      else $error("masked flags asserted management output");
   a_host_level: assert property (cfg_host_nmi_sel_in && host_act |=> host_irq_out)
      else $error("nmi mode output not high");
   a_reset_gate: assert property (rst_pl.start |-> q.mgmt_hi[MIM_BIT_RESET_EN])
      else $error("reset pulse started without enable");
   a_case_clear_self: assert property (case_pl.done |=> !q.host_hi[MIM_BIT_CASE_CLEAR])
      else $error("case clear bit did not self clear");
   a_flags_bit7_zero: assert property (rd_flags |=> reg_rdata_out[7] == 1'b0)
      else $error("reserved flag bit read nonzero");
   a_vid_readback: assert property (reg_rd_in && reg_addr_in == MIM_ADDR_DIV_VID
         |=> reg_rdata_out[3:0] == $past(voltage_ident_inputs_in))
      else $error("identification bits wrong");
   a_fan_div_one: assert property (first_tachometer_in && q.fan_div[1:0] == 2'b00
         |=> first_tachometer_div_out)
      else $error("divide by one lost a pulse");

   c_flags_read: cover property (rd_flags && q.flags2 != 7'h00);
   c_case_pulse: cover property (case_pl.start);
   c_reset_pulse: cover property (rst_pl.start);
   c_both_irq: cover property (!mgmt_irq_n_out && host_irq_out);
endmodule
`default_nettype wire

// >>> mim_pkg.sv
`default_nettype none
package mim_pkg;
   // register index on the pointer/data port
   localparam logic [6:0] MIM_ADDR_FLAGS2   = 7'h42;
   localparam logic [6:0] MIM_ADDR_MGMT_LO  = 7'h43;
   localparam logic [6:0] MIM_ADDR_MGMT_HI  = 7'h44;
   localparam logic [6:0] MIM_ADDR_HOST_LO  = 7'h45;
   localparam logic [6:0] MIM_ADDR_HOST_HI  = 7'h46;
   localparam logic [6:0] MIM_ADDR_DIV_VID  = 7'h47;
   localparam logic [6:0] MIM_ADDR_SLAVE    = 7'h48;

   // reset values
   localparam logic [6:0] MIM_RST_FLAGS2    = 7'h00;
   localparam logic [7:0] MIM_RST_MGMT_LO   = 8'h00;
   localparam logic [7:0] MIM_RST_MGMT_HI   = 8'h00;
   localparam logic [7:0] MIM_RST_HOST_LO   = 8'h00;
   localparam logic [7:0] MIM_RST_HOST_HI   = 8'h40;
   localparam logic [3:0] MIM_RST_FAN_DIV   = 4'h5;
   localparam logic [6:0] MIM_RST_SLAVE     = 7'h2d;

   // field positions
   localparam int MIM_BIT_RESET_EN   = 7;
   localparam int MIM_BIT_CASE_CLEAR = 7;
   localparam int MIM_FIRST_TACHOMETER_LSB       = 4;
   localparam int MIM_SECOND_TACHOMETER_LSB       = 6;
   localparam int MIM_VID_W          = 4;
   localparam int MIM_EV_CH4         = 0;
   localparam int MIM_EV_INV_A       = 1;
   localparam int MIM_EV_INV_B       = 2;
   localparam int MIM_EV_TACH3       = 3;
   localparam int MIM_EV_CASE        = 4;
   localparam int MIM_EV_POST_FULL   = 5;
   localparam int MIM_EV_CHAIN       = 6;
   localparam int MIM_EV_NUM         = 7;
   localparam logic [4:0] MIM_POST_LAST = 5'h1f;

   // timing
   localparam int MIM_CLK_KHZ        = 25000;
   localparam int MIM_CLEAR_PULSE_MS = 20;
   localparam int MIM_PULSE_CYCLES   = MIM_CLEAR_PULSE_MS * MIM_CLK_KHZ;
endpackage
`default_nettype wire

// >>> mim_pulse_if.sv
`timescale 1ns/10ps
`default_nettype none
interface mim_pulse_if;
   logic start;
   logic busy;
   logic done;
   modport ctl (output start, input busy, input done);
   modport gen (input start, output busy, output done);
endinterface
`default_nettype wire

// >>> mim_pulse_timer.sv
`timescale 1ns/10ps
`default_nettype none
module mim_pulse_timer
   import mim_pkg::*;
#(
   parameter int CYCLES = MIM_PULSE_CYCLES
) (
   input  wire logic ref_clk_in,
   input  wire logic rst_n_in,
   mim_pulse_if.gen  pl
);
   localparam int W = $clog2(CYCLES + 1);

   typedef struct packed {
      logic         busy;
      logic [W-1:0] cnt;
   } mim_pulse_state_type;

   mim_pulse_state_type q;
   mim_pulse_state_type d;

   // busy holds exactly CYCLES clocks; done marks its last one
   always_comb begin
      d = q;
      if (q.busy) begin
         if (q.cnt == W'(1)) begin
            d.busy = 1'b0;
            d.cnt  = '0;
         end else begin
            d.cnt = q.cnt - W'(1);
         end
      end else if (pl.start) begin
         d.busy = 1'b1;
         d.cnt  = W'(CYCLES);
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pl.busy = q.busy;
   assign pl.done = q.busy && (q.cnt == W'(1));

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   a_pulse_min_len: assert property (pl.start && !pl.busy |=> pl.busy [*8])
      else $error("pulse shorter than eight cycles");
   a_pulse_done_end: assert property (pl.done |=> !pl.busy)
      else $error("pulse still busy after done");
endmodule
`default_nettype wire

// >>> mim_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module mim_host_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] rdata_in,
   output logic [6:0]      addr_out,
   output logic            wr_out,
   output logic            rd_out,
   output logic [7:0]      wdata_out
);
   initial begin
      addr_out  = 7'h00;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      wdata_out = 8'h00;
   end
   // strobe held one edge; idle lines flip so a stale value never passes
   task automatic put(input logic [6:0] a, input logic [7:0] d, input logic w);
      addr_out  = a;
      wdata_out = d;
      wr_out    = w;
      rd_out    = !w;
      @(posedge clk_in);
      #1;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      addr_out  = ~a;
      wdata_out = ~d;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      put(a, d, 1'b1);
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      put(a, 8'h00, 1'b0);
      d = rdata_in;
   endtask
   // one clear pulse, then poll until the bit drops
   task automatic case_clear(input logic [7:0] keep);
      logic [7:0] v;
      wr(7'h46, keep | 8'h80);
      v = 8'h80;
      for (int i = 0; i < 200 && v[7]; i++) rd(7'h46, v);
   endtask
endmodule
`default_nettype wire

// >>> test_monitor_interrupt_mask_config.sv
`timescale 1ns/10ps
`default_nettype none
module test_monitor_interrupt_mask_config;
   localparam int PC = 16;
   logic        clk, rstn, wr, rd, rdone, rpn, cpo, coen, d1, d2, mgn, hirq;
   logic [6:0]  addr, sa;
   logic [7:0]  wdata, rdata, v, fl, m1, m2, m3, m4, r;
   logic [7:0]  f1 = 8'h00;
   logic        en_m = 0, en_h = 0, iclr = 0, nsel = 0, rreq = 0;
   logic        ch4 = 0, ia = 0, ib = 0, t3 = 0, case_drv = 0, pw = 0;
   logic        chain_n = 1, t1 = 0, t2 = 0;
   logic [4:0]  pp = 5'h1f;
   logic [3:0]  voltage_ident_inputs = 4'h0;
   wire logic   pin;
   logic [31:0] seed = 32'h65f3;
   int          n_mismatch = 0, comparisons = 0, cnt = 0, rcnt = 0, c1 = 0, c2 = 0;
   logic [7:0]  rv [7];

   // open-drain case pin: our pulse wins while enabled
   assign pin = !coen ? cpo : case_drv;

   mim_host_model host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
      .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

   mim_irq_mask_ctrl #(.PULSE_CYCLES(PC)) dut (
      .ref_clk_in(clk), .resetn_in(rstn), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .first_flags_in(f1),
      .cfg_mgmt_irq_en_in(en_m), .cfg_host_irq_en_in(en_h),
      .cfg_int_clear_in(iclr), .cfg_host_nmi_sel_in(nsel),
      .cfg_reset_req_in(rreq), .reset_done_out(rdone), .reset_pulse_n_out(rpn),
      .positive_channel_four_limit_in(ch4), .inverting_channel_a_limit_in(ia),
      .inverting_channel_b_limit_in(ib), .third_tachometer_limit_in(t3),
      .case_open_pin_in(pin), .case_open_pin_out(cpo),
      .case_open_pin_oe_n_out(coen), .post_write_in(pw), .post_ptr_in(pp),
      .chained_irq_in_pin_in(chain_n), .voltage_ident_inputs_in(voltage_ident_inputs),
      .first_tachometer_in(t1), .second_tachometer_in(t2),
      .first_tachometer_div_out(d1), .second_tachometer_div_out(d2),
      .serial_slave_address_out(sa), .mgmt_irq_n_out(mgn), .host_irq_out(hirq));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      if (!coen) cnt++;
      if (!rpn) rcnt++;
      if (d1) c1++;
      if (d2) c2++;
   end

   function automatic logic [7:0] rnd();
      for (int i = 0; i < 8; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction

   function automatic logic irq_on(logic en, logic [7:0] a, b, ma, mb);
      return en && !iclr && ((|(a & ~ma)) || (|(b[6:0] & ~mb[6:0])));
   endfunction

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic fire(input int b, input logic on);
      case (b)
         0: ch4 = on;
         1: ia = on;
         2: ib = on;
         3: t3 = on;
         4: case_drv = on;
         5: pw = on;
         default: chain_n = !on;
      endcase
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      n_mismatch++;
      conclude();
   end

   initial begin
      rstn = 1'b0;
      r = rnd();
      voltage_ident_inputs = r[3:0];
      repeat (20) @(posedge clk);
      #1;
      rstn = 1'b1;
      tick(4);
      rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, {4'h5, voltage_ident_inputs}, 8'h2d};
      for (int i = 0; i < 7; i++) begin
         host.rd(7'h42 + 7'(i), v);
         check("reset value", v, rv[i]);
      end
      host.rd(7'h49, v);
      check("unmapped", v, 8'h00);
      check("slave addr out", {1'b0, sa}, 8'h2d);
      $display("test reset values done");

      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 7; i++) begin
            r = rnd();
            if (i == 4) r[7] = 1'b0;
            host.wr(7'h42 + 7'(i), r);
            host.rd(7'h42 + 7'(i), v);
            rv = '{8'h00, r, r, r, r, {r[7:4], voltage_ident_inputs}, {1'b0, r[6:0]}};
            check("readback", v, rv[i]);
         end
         check("slave addr out", {1'b0, sa}, {1'b0, r[6:0]});
      end
      $display("test register access done");

      for (int k = 0; k < 14; k++) begin
         m1 = rnd();
         m2 = rnd() & 8'h7f;
         m3 = rnd();
         m4 = rnd() & 8'h7f;
         host.wr(7'h43, m1);
         host.wr(7'h44, m2);
         host.wr(7'h45, m3);
         host.wr(7'h46, m4);
         r = rnd();
         en_m = r[0];
         en_h = r[1];
         nsel = r[2];
         iclr = (r[5:3] == 3'h0) || k == 6;
         f1 = rnd() & rnd() & rnd();
         host.rd(7'h42, v);
         fire(k % 7, 1'b1);
         tick(1);
         fire(k % 7, 1'b0);
         tick(2);
         fl = iclr ? 8'h00 : 8'h01 << (k % 7);
         check("mgmt irq", {7'h0, mgn}, {7'h0, !irq_on(en_m, f1, fl, m1, m2)});
         check("host irq", {7'h0, hirq}, {7'h0, irq_on(en_h, f1, fl, m3, m4) ~^ nsel});
         host.rd(7'h42, v);
         check("flags", v, fl);
      end
      iclr = 1'b0;
      pp = 5'h1e;
      fire(5, 1'b1);
      tick(1);
      fire(5, 1'b0);
      tick(1);
      host.rd(7'h42, v);
      check("post not last", v, 8'h00);
      $display("test flags and outputs done");

      cnt = 0;
      host.case_clear(8'h40);
      tick(2);
      check("clear pulse", cnt[7:0], 8'(PC));
      check("pin level", {7'h0, cpo}, 8'h00);
      host.rd(7'h46, v);
      check("clear self", v, 8'h40);
      $display("test case clear done");

      host.wr(7'h44, 8'h00);
      rcnt = 0;
      rreq = 1'b1;
      tick(40);
      check("reset gated", rcnt[7:0], 8'h00);
      host.wr(7'h44, 8'h80);
      for (int i = 0; i < 60 && rdone !== 1'b1; i++) tick(1);
      rreq = 1'b0;
      tick(4);
      check("reset pulse", rcnt[7:0], 8'(PC));
      $display("test reset pulse done");

      for (int s = 0; s < 4; s++) begin
         host.wr(7'h47, {2'(3 - s), 2'(s), 4'h0});
         c1 = 0;
         c2 = 0;
         repeat (16) begin
            t1 = 1'b1;
            t2 = 1'b1;
            tick(1);
            t1 = 1'b0;
            t2 = 1'b0;
            tick(1);
         end
         tick(2);
         check("tach one", c1[7:0], 8'(16 >> s));
         check("tach two", c2[7:0], 8'(16 >> (3 - s)));
      end
      $display("test tach divide done");
      conclude();
   end
endmodule
`default_nettype wire
